//--- src/pxm_port_mem_if.sv
// Four byte ports with quasi-bidirectional pins, external program/data bus
// cycles on the low and high address ports, and alternate-function pin muxing.
// Core side is on clk; pins are asynchronous and are synchronised before use.
`timescale 1ns/1ps
`default_nettype none

module pxm_port_mem_if #(
  parameter int OnchipRomBytes = pxm_pkg::ONCHIP_ROM_BYTES,
  parameter int AddrCycles     = pxm_pkg::ADDR_CYCLES,
  parameter int StrobeCycles   = pxm_pkg::STROBE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  // Program fetch request
  input  wire logic        fetchReq,
  input  wire logic [15:0] fetchAddr,
  output var  logic        fetchDone,
  output var  logic [7:0]  fetchData,
  // External data request
  input  wire logic        dataReq,
  input  wire logic        dataWrite,
  input  wire logic        dataWide,
  input  wire logic [15:0] dataAddr,
  input  wire logic [7:0]  dataWdata,
  output var  logic        dataDone,
  output var  logic [7:0]  dataRdata,
  output var  logic        busBusy,
  // On-chip program array
  output var  logic        romRdEn,
  output var  logic [15:0] romAddr,
  input  wire logic [7:0]  romData,
  // Special-function port access
  input  wire logic        sfrWr,
  input  wire logic        sfrBitWr,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [2:0]  sfrBitIdx,
  input  wire logic        sfrBitVal,
  input  wire logic [7:0]  sfrWdata,
  output var  logic [31:0] portLatch,
  output var  logic [31:0] portPins,
  // Peripheral side of alternate functions
  input  wire logic [1:0]  irqEdgeMode,
  output var  logic [1:0]  irqReq,
  output var  logic [1:0]  countIn,
  input  wire logic        serShiftMode,
  input  wire logic        serTxd,
  input  wire logic        serShiftClk,
  input  wire logic        serDataOut,
  input  wire logic        serDataOe,
  output var  logic        serRxd,
  // Pins
  input  wire logic [7:0]  lowAddressDataPortIn,
  output var  logic [7:0]  lowAddressDataPortOut,
  output var  logic [7:0]  lowAddressDataPortOe,
  input  wire logic [7:0]  gpPortIn,
  output var  logic [7:0]  gpPortOut,
  output var  logic [7:0]  gpPortOe,
  input  wire logic [7:0]  highAddressPortIn,
  output var  logic [7:0]  highAddressPortOut,
  output var  logic [7:0]  highAddressPortOe,
  input  wire logic [7:0]  altFunctionPortIn,
  output var  logic [7:0]  altFunctionPortOut,
  output var  logic [7:0]  altFunctionPortOe,
  output var  logic        addrLatchStrobe,
  output var  logic        codeFetchStrobeN
);

  localparam int CNT_W_L = pxm_pkg::CNT_W;
  localparam logic [16:0] RomTop   = 17'(OnchipRomBytes);
  localparam logic [CNT_W_L-1:0] AddrLast = CNT_W_L'(AddrCycles - 1);
  localparam logic [CNT_W_L-1:0] StrbLast = CNT_W_L'(StrobeCycles - 1);

  // Port decode: valid bit and port index
  function automatic logic [2:0] portDecode(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h0;
    case (a)
      pxm_pkg::SFR_LOW_PORT:  r = {1'b1, pxm_pkg::PXM_PORT_LOW};
      pxm_pkg::SFR_GP_PORT:   r = {1'b1, pxm_pkg::PXM_PORT_GP};
      pxm_pkg::SFR_HIGH_PORT: r = {1'b1, pxm_pkg::PXM_PORT_HIGH};
      pxm_pkg::SFR_ALT_PORT:  r = {1'b1, pxm_pkg::PXM_PORT_ALT};
      default:                r = 3'h0;
    endcase
    return r;
  endfunction

  pxm_pkg::pxm_state_t state_q;
  logic [CNT_W_L-1:0]  cnt_q;
  logic                isFetch_q;
  logic                isWrite_q;
  logic                isWide_q;
  logic [15:0]         addr_q;
  logic [7:0]          wdata_q;
  logic [31:0]         pinMeta_q;
  logic [31:0]         pinSync_q;
  logic [1:0]          irqPrev_q;
  logic [2:0]          dec;
  logic [4:0]          base;
  logic                inCycle;
  logic [7:0]          lowOut_d;
  logic [7:0]          lowOe_d;
  logic [7:0]          highOut_d;
  logic [7:0]          highOe_d;
  logic [7:0]          alt_d;
  logic [7:0]          altVal_d;

  // accumulator address never decodes as a port
  assign dec  = (sfrAddr == pxm_pkg::SFR_ACCUMULATOR) ? 3'h0 : portDecode(sfrAddr);
  assign base = {dec[1:0], 3'h0};
  assign inCycle = (state_q != pxm_pkg::PXM_IDLE) && (state_q != pxm_pkg::PXM_ROM);

  // Pin synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= {4{pxm_pkg::PORT_RESET}};
      pinSync_q <= {4{pxm_pkg::PORT_RESET}};
    end else begin
      pinMeta_q <= {altFunctionPortIn, highAddressPortIn, gpPortIn, lowAddressDataPortIn};
      pinSync_q <= pinMeta_q;
    end
  end

  assign portPins = pinSync_q;

  // byte and bit writes to port latches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      portLatch <= {4{pxm_pkg::PORT_RESET}};
    end else if (dec[2] && sfrWr) begin
      portLatch[base +: 8] <= sfrWdata;
    end else if (dec[2] && sfrBitWr) begin
      portLatch[base + 5'(sfrBitIdx)] <= sfrBitVal;
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= pxm_pkg::PXM_IDLE;
      cnt_q     <= '0;
      isFetch_q <= 1'b0;
      isWrite_q <= 1'b0;
      isWide_q  <= 1'b0;
      addr_q    <= 16'h0000;
      wdata_q   <= 8'h00;
    end else begin
      case (state_q)
        pxm_pkg::PXM_IDLE: begin
          cnt_q <= '0;
          if (dataReq) begin
            // data requests never serve a fetch
            isFetch_q <= 1'b0;
            isWrite_q <= dataWrite;
            isWide_q  <= dataWide;
            addr_q    <= dataAddr;
            wdata_q   <= dataWdata;
            state_q   <= pxm_pkg::PXM_ADDR;
          end else if (fetchReq) begin
            isFetch_q <= 1'b1;
            isWrite_q <= 1'b0;
            isWide_q  <= 1'b1;
            addr_q    <= fetchAddr;
            if ({1'b0, fetchAddr} < RomTop) begin
              state_q <= pxm_pkg::PXM_ROM;
            end else begin
              state_q <= pxm_pkg::PXM_ADDR;
            end
          end
        end
        pxm_pkg::PXM_ADDR: begin
          if (cnt_q == AddrLast) begin
            cnt_q   <= '0;
            state_q <= pxm_pkg::PXM_STROBE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        pxm_pkg::PXM_STROBE: begin
          if (cnt_q == StrbLast) begin
            cnt_q   <= '0;
            state_q <= pxm_pkg::PXM_DONE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        pxm_pkg::PXM_DONE: state_q <= pxm_pkg::PXM_IDLE;
        pxm_pkg::PXM_ROM:  state_q <= pxm_pkg::PXM_IDLE;
        default:           state_q <= pxm_pkg::PXM_IDLE;
      endcase
    end
  end

  // Answers to the core
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetchDone <= 1'b0;
      fetchData <= 8'h00;
      dataDone  <= 1'b0;
      dataRdata <= 8'h00;
      busBusy   <= 1'b0;
      romRdEn   <= 1'b0;
      romAddr   <= 16'h0000;
    end else begin
      fetchDone <= 1'b0;
      dataDone  <= 1'b0;
      romRdEn   <= (state_q == pxm_pkg::PXM_IDLE) && !dataReq && fetchReq
                   && ({1'b0, fetchAddr} < RomTop);
      romAddr   <= fetchAddr;
      busBusy   <= (state_q != pxm_pkg::PXM_IDLE) || dataReq || fetchReq;
      if (state_q == pxm_pkg::PXM_ROM) begin
        fetchDone <= 1'b1;
        fetchData <= romData;
      end
      // Read data sampled from the synchronised low port at strobe end
      if (state_q == pxm_pkg::PXM_STROBE && cnt_q == StrbLast) begin
        if (isFetch_q) begin
          fetchDone <= 1'b1;
          fetchData <= pinSync_q[pxm_pkg::PIN_LOW +: 8];
        end else begin
          dataDone <= 1'b1;
          if (!isWrite_q) begin
            dataRdata <= pinSync_q[pxm_pkg::PIN_LOW +: 8];
          end
        end
      end
    end
  end

  // Next pin values
  always_comb begin
    // address phase, then data on the same pins
    lowOut_d = pxm_pkg::BYTE_ALL_OFF;
    lowOe_d  = ~portLatch[pxm_pkg::PIN_LOW +: 8];
    if (state_q == pxm_pkg::PXM_ADDR) begin
      lowOut_d = addr_q[7:0];
      lowOe_d  = pxm_pkg::BYTE_ALL_ON;
    end else if (state_q == pxm_pkg::PXM_STROBE && isWrite_q) begin
      lowOut_d = wdata_q;
      lowOe_d  = pxm_pkg::BYTE_ALL_ON;
    end else if (inCycle) begin
      lowOe_d  = pxm_pkg::BYTE_ALL_OFF;
    end
    // upper address held for the access
    // paged access leaves the high port to software
    highOut_d = pxm_pkg::BYTE_ALL_OFF;
    highOe_d  = ~portLatch[pxm_pkg::PIN_HIGH +: 8];
    if (inCycle && (isFetch_q || isWide_q)) begin
      highOut_d = addr_q[15:8];
      highOe_d  = pxm_pkg::BYTE_ALL_ON;
    end
    // unused functions stay high so latch rules
    alt_d = pxm_pkg::BYTE_ALL_ON;
    alt_d[pxm_pkg::ALT_READ]  = !(state_q == pxm_pkg::PXM_STROBE && !isFetch_q && !isWrite_q);
    alt_d[pxm_pkg::ALT_STORE] = !(state_q == pxm_pkg::PXM_STROBE && !isFetch_q && isWrite_q);
    alt_d[pxm_pkg::ALT_TXD]   = serShiftMode ? serShiftClk : serTxd;
    // shift-mode data drive on the receive pin
    alt_d[pxm_pkg::ALT_RXD]   = serDataOe ? serDataOut : 1'b1;
    altVal_d = portLatch[pxm_pkg::PIN_ALT +: 8] & alt_d;
  end

  // Registered pin drivers; quasi pins only pull low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowAddressDataPortOut <= pxm_pkg::BYTE_ALL_OFF;
      lowAddressDataPortOe  <= pxm_pkg::BYTE_ALL_OFF;
      gpPortOut             <= pxm_pkg::BYTE_ALL_OFF;
      gpPortOe              <= pxm_pkg::BYTE_ALL_OFF;
      highAddressPortOut    <= pxm_pkg::BYTE_ALL_OFF;
      highAddressPortOe     <= pxm_pkg::BYTE_ALL_OFF;
      altFunctionPortOut    <= pxm_pkg::BYTE_ALL_OFF;
      altFunctionPortOe     <= pxm_pkg::BYTE_ALL_OFF;
      addrLatchStrobe       <= 1'b0;
      codeFetchStrobeN      <= 1'b1;
    end else begin
      lowAddressDataPortOut <= lowOut_d;
      lowAddressDataPortOe  <= lowOe_d;
      gpPortOut             <= pxm_pkg::BYTE_ALL_OFF;
      gpPortOe              <= ~portLatch[pxm_pkg::PIN_GP +: 8];
      highAddressPortOut    <= highOut_d;
      highAddressPortOe     <= highOe_d;
      altFunctionPortOut    <= pxm_pkg::BYTE_ALL_OFF;
      altFunctionPortOe     <= ~altVal_d;
      addrLatchStrobe       <= (state_q == pxm_pkg::PXM_ADDR);
      // code strobe only on external fetch
      codeFetchStrobeN      <= !(state_q == pxm_pkg::PXM_STROBE && isFetch_q);
    end
  end

  // Alternate inputs to peripherals
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqPrev_q <= 2'h3;
      irqReq    <= 2'h0;
      countIn   <= 2'h3;
      serRxd    <= 1'b1;
    end else begin
      irqPrev_q <= {pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_IRQ1],
                    pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_IRQ0]};
      for (int i = 0; i < 2; i++) begin
        irqReq[i] <= irqEdgeMode[i]
                     ? (irqPrev_q[i] && !pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_IRQ0 + i])
                     : !pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_IRQ0 + i];
      end
      countIn   <= {pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_CNT1],
                    pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_CNT0]};
      serRxd    <= pinSync_q[pxm_pkg::PIN_ALT + pxm_pkg::ALT_RXD];
    end
  end

endmodule

`default_nettype wire

//--- src/pxm_pkg.sv
// Constants, states and encodings for the port and external memory interface.
// Assumes one core clock; external parts sit on the pins with pull-ups on quasi pins.
// Operation
// - One 64K program space; lowest 4K on-chip, the rest fetched off-chip.
// - Instruction fetches use program memory only, never data memory.
// - No store strobe is ever issued for program memory.
// - Low address/data port carries the low address first, then the data byte.
// - High address port drives the upper address on off-chip fetches and sixteen-bit data accesses.
// - 32 pins in four byte ports, bit and byte access, input or output.
// - Alternate-function pins carry their function when used, else plain I/O.
// - Active-low read strobe on alternate port bit 7 for external data reads.
// - Active-low store strobe on alternate port bit 6 for external data writes.
// - Alternate port bits 2 and 3 take interrupts, low level or falling edge.
// - Alternate port bits 4 and 5 are counter inputs zero and one.
// - Alternate port bit 1 is serial transmit, or shift clock in shift mode.
// - Alternate port bit 0 is serial receive, or bidirectional data in shift mode.
// - Accumulator owns its own special-function address, apart from the ports.
// - Separate active-low code fetch strobe gates external program memory.
// - Optional eight-bit paged data access leaves high address port as I/O.

package pxm_pkg;

  localparam logic [16:0] PROG_SPACE_BYTES = 17'h10000;
  localparam int          ONCHIP_ROM_BYTES = 4096;
  localparam int          ADDR_CYCLES      = 1;
  localparam int          STROBE_CYCLES    = 4;
  localparam int          CNT_W            = 4;

  localparam logic [7:0]  PORT_RESET       = 8'hff;
  localparam logic [7:0]  BYTE_ALL_ON      = 8'hff;
  localparam logic [7:0]  BYTE_ALL_OFF     = 8'h00;

  localparam logic [7:0]  SFR_LOW_PORT     = 8'h80;
  localparam logic [7:0]  SFR_GP_PORT      = 8'h90;
  localparam logic [7:0]  SFR_HIGH_PORT    = 8'ha0;
  localparam logic [7:0]  SFR_ALT_PORT     = 8'hb0;
  localparam logic [7:0]  SFR_ACCUMULATOR  = 8'he0;

  localparam int ALT_RXD    = 0;
  localparam int ALT_TXD    = 1;
  localparam int ALT_IRQ0   = 2;
  localparam int ALT_IRQ1   = 3;
  localparam int ALT_CNT0   = 4;
  localparam int ALT_CNT1   = 5;
  localparam int ALT_STORE  = 6;
  localparam int ALT_READ   = 7;

  localparam int PIN_LOW  = 0;
  localparam int PIN_GP   = 8;
  localparam int PIN_HIGH = 16;
  localparam int PIN_ALT  = 24;

  typedef enum logic [1:0] {
    PXM_PORT_LOW  = 2'h0,
    PXM_PORT_GP   = 2'h1,
    PXM_PORT_HIGH = 2'h2,
    PXM_PORT_ALT  = 2'h3
  } pxm_port_t;

  typedef enum logic [2:0] {
    PXM_IDLE   = 3'h0,
    PXM_ADDR   = 3'h1,
    PXM_STROBE = 3'h3,
    PXM_DONE   = 3'h2,
    PXM_ROM    = 3'h6
  } pxm_state_t;

endpackage

//--- dv/pxm_port_mem_if_asserts.sv
// Concurrent checks on bus strobes, fetch routing and interrupt inputs.
// Bound into every instance of the port and memory block; one clock.
`timescale 1ns/1ps
`default_nettype none
module pxm_port_mem_if_asserts #(
  parameter int OnchipRomBytes = pxm_pkg::ONCHIP_ROM_BYTES
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        fetchDone,
  input wire logic        dataDone,
  input wire logic        romRdEn,
  input wire logic [15:0] romAddr,
  input wire logic [1:0]  irqEdgeMode,
  input wire logic [1:0]  irqReq,
  input wire logic [7:0]  lowAddressDataPortOe,
  input wire logic [7:0]  highAddressPortOe,
  input wire logic [7:0]  altFunctionPortOut,
  input wire logic [7:0]  altFunctionPortOe,
  input wire logic        addrLatchStrobe,
  input wire logic        codeFetchStrobeN
);
  wire rdOn  = altFunctionPortOe[7] & ~altFunctionPortOut[7];
  wire stOn  = altFunctionPortOe[6] & ~altFunctionPortOut[6];
  wire anyOn = rdOn | stOn | ~codeFetchStrobeN;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_strobeOn;
    anyOn && !addrLatchStrobe;
  endsequence
  sequence s_fetchPulse;
    !codeFetchStrobeN [*4] ##1 codeFetchStrobeN;
  endsequence
  property p_oneStrobe;
    $onehot0({rdOn, stOn, ~codeFetchStrobeN});
  endproperty
  a_oneStrobe: assert property (p_oneStrobe) else $error("two strobes at once");
  property p_aleDrives;
    addrLatchStrobe |-> lowAddressDataPortOe == 8'hff;
  endproperty
  a_aleDrives: assert property (p_aleDrives) else $error("address phase undriven");
  property p_aleThenStrobe;
    $rose(addrLatchStrobe) |=> s_strobeOn;
  endproperty
  a_aleThenStrobe: assert property (p_aleThenStrobe) else $error("no strobe after address");
  property p_anyAfterAle;
    $rose(anyOn) |-> $past(addrLatchStrobe);
  endproperty
  a_anyAfterAle: assert property (p_anyAfterAle) else $error("strobe without address");
  property p_readFloats;
    rdOn |-> lowAddressDataPortOe == 8'h00;
  endproperty
  a_readFloats: assert property (p_readFloats) else $error("bus driven during read");
  property p_storeDrives;
    stOn |-> lowAddressDataPortOe == 8'hff;
  endproperty
  a_storeDrives: assert property (p_storeDrives) else $error("store data not driven");
  property p_fetchGate;
    !codeFetchStrobeN |-> lowAddressDataPortOe == 8'h00 && highAddressPortOe == 8'hff;
  endproperty
  a_fetchGate: assert property (p_fetchGate) else $error("bad fetch bus drive");
  property p_fetchLen;
    $fell(codeFetchStrobeN) |-> s_fetchPulse;
  endproperty
  a_fetchLen: assert property (p_fetchLen) else $error("fetch strobe length");
  property p_doneAfterAle;
    $rose(addrLatchStrobe) |-> ##[3:5] (fetchDone || dataDone);
  endproperty
  a_doneAfterAle: assert property (p_doneAfterAle) else $error("bus cycle never done");
  property p_romLow;
    romRdEn |-> (romAddr < OnchipRomBytes) ##1 fetchDone;
  endproperty
  a_romLow: assert property (p_romLow) else $error("bad on-chip fetch");
  property p_irqPulse;
    irqEdgeMode[0] && irqReq[0] |=> !irqReq[0];
  endproperty
  a_irqPulse: assert property (p_irqPulse) else $error("edge request not a pulse");
endmodule
bind pxm_port_mem_if pxm_port_mem_if_asserts #(.OnchipRomBytes(OnchipRomBytes)) u_chk (
  .clk(clk), .rstn(rstn), .fetchDone(fetchDone), .dataDone(dataDone), .romRdEn(romRdEn),
  .romAddr(romAddr), .irqEdgeMode(irqEdgeMode), .irqReq(irqReq),
  .lowAddressDataPortOe(lowAddressDataPortOe), .highAddressPortOe(highAddressPortOe),
  .altFunctionPortOut(altFunctionPortOut), .altFunctionPortOe(altFunctionPortOe),
  .addrLatchStrobe(addrLatchStrobe), .codeFetchStrobeN(codeFetchStrobeN));
`default_nettype wire

//--- dv/pxm_ext_mem_model.sv
// External program and data memory on the multiplexed bus.
// Assumes the bench resolves pins and pulls released lines high.
`timescale 1ns/1ps
`default_nettype none
module pxm_ext_mem_model #(
  parameter int Lag = 0
) (
  input  wire logic        clk,
  input  wire logic        ale,
  input  wire logic        fetchN,
  input  wire logic [7:0]  loO,
  input  wire logic [7:0]  hiPin,
  input  wire logic [7:0]  alO,
  input  wire logic [7:0]  alE,
  output var  logic        memEn,
  output var  logic [7:0]  memD,
  output var  logic [15:0] wrAddr,
  output var  logic [7:0]  wrData
);
  logic [7:0] aLow = 8'h00;
  logic       lagQ = 1'b0;
  wire        want = (alE[7] & ~alO[7]) | ~fetchN;
  always_ff @(posedge clk) begin
    if (ale) begin
      aLow <= loO;
    end
    lagQ <= want;
  end
  assign memEn = want & ((Lag == 0) | lagQ);
  assign memD  = aLow ^ hiPin ^ 8'h5a;
  always_ff @(posedge clk) begin
    if (alE[6] & ~alO[6]) begin
      wrAddr <= {hiPin, aLow};
      wrData <= loO;
    end
  end
endmodule
`default_nettype wire

//--- dv/test_port_and_external_memory_interface.sv
// Self-checking bench: fetches, data cycles, port writes, alternate pins.
// Assumes the memory model and bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_port_and_external_memory_interface;
  localparam int LAT = pxm_pkg::ADDR_CYCLES + pxm_pkg::STROBE_CYCLES + 1;
  localparam int STB = pxm_pkg::STROBE_CYCLES;
  logic        clk = 0, rstn = 0, fetchReq = 0, dataReq = 0, dataWrite = 0, dataWide = 0;
  logic        sfrWr = 0, sfrBitWr = 0, sfrBitVal = 0, serShiftMode = 0, serTxd = 1;
  logic        serShiftClk = 1, serDataOut = 1, serDataOe = 0;
  logic [15:0] fetchAddr = 0, dataAddr = 0;
  logic [7:0]  dataWdata = 0, sfrAddr = 0, sfrWdata = 0, altExt = 8'hff;
  logic [2:0]  sfrBitIdx = 0;
  logic [1:0]  irqEdgeMode = 0;
  wire         fetchDone, dataDone, codeFetchStrobeN, addrLatchStrobe, serRxd, memEn, busBusy;
  wire [1:0]   irqReq, countIn;
  wire [7:0]   fetchData, dataRdata, memD, wrData, loO, loE, gpO, gpE, hiO, hiE, alO, alE;
  wire [15:0]  romAddr, wrAddr;
  wire [31:0]  portLatch, portPins;
  wire [7:0]   romData = romAddr[7:0] ^ 8'hc3;
  wire [7:0]   loI = (loE & loO) | (~loE & (memEn ? memD : 8'hff));
  wire [7:0]   gpI = (gpE & gpO) | ~gpE;
  wire [7:0]   hiI = (hiE & hiO) | ~hiE;
  wire [7:0]   alI = (alE & alO) | (~alE & altExt);
  int          failures = 0, checked = 0, cyc = 0, n, nF, nR, nS;
  pxm_port_mem_if u_dut (
    .clk(clk), .rstn(rstn), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchDone(fetchDone), .fetchData(fetchData), .dataReq(dataReq), .dataWrite(dataWrite),
    .dataWide(dataWide), .dataAddr(dataAddr), .dataWdata(dataWdata), .dataDone(dataDone),
    .dataRdata(dataRdata), .busBusy(busBusy), .romRdEn(), .romAddr(romAddr), .romData(romData),
    .sfrWr(sfrWr), .sfrBitWr(sfrBitWr), .sfrAddr(sfrAddr), .sfrBitIdx(sfrBitIdx),
    .sfrBitVal(sfrBitVal), .sfrWdata(sfrWdata), .portLatch(portLatch), .portPins(portPins),
    .irqEdgeMode(irqEdgeMode), .irqReq(irqReq), .countIn(countIn),
    .serShiftMode(serShiftMode), .serTxd(serTxd), .serShiftClk(serShiftClk),
    .serDataOut(serDataOut), .serDataOe(serDataOe), .serRxd(serRxd),
    .lowAddressDataPortIn(loI), .lowAddressDataPortOut(loO), .lowAddressDataPortOe(loE),
    .gpPortIn(gpI), .gpPortOut(gpO), .gpPortOe(gpE), .highAddressPortIn(hiI),
    .highAddressPortOut(hiO), .highAddressPortOe(hiE), .altFunctionPortIn(alI),
    .altFunctionPortOut(alO), .altFunctionPortOe(alE),
    .addrLatchStrobe(addrLatchStrobe), .codeFetchStrobeN(codeFetchStrobeN));
  pxm_ext_mem_model u_mem (
    .clk(clk), .ale(addrLatchStrobe), .fetchN(codeFetchStrobeN), .loO(loO), .hiPin(hiI),
    .alO(alO), .alE(alE), .memEn(memEn), .memD(memD), .wrAddr(wrAddr), .wrData(wrData));
  always #20 clk = ~clk;
  function automatic logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  // One request, counting each strobe's low cycles until done
  task automatic go(input logic f, w, wd, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    fetchReq  <= f;
    dataReq   <= !f;
    fetchAddr <= a;
    dataAddr  <= a;
    dataWrite <= w;
    dataWide  <= wd;
    dataWdata <= d;
    @(posedge clk);
    fetchReq <= 0;
    dataReq  <= 0;
    n  = 0;
    nF = 0;
    nR = 0;
    nS = 0;
    do begin
      @(negedge clk);
      n++;
      nF += !codeFetchStrobeN;
      nR += alE[7] & !alO[7];
      nS += alE[6] & !alO[6];
    end while (fetchDone !== 1'b1 && dataDone !== 1'b1 && n < 20);
    chk("busyInCycle", busBusy, 1);
    repeat (2) @(negedge clk);
    chk("busyAfter", busBusy, 0);
  endtask
  task automatic sfr(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrWr     <= !b;
    sfrBitWr  <= b;
    sfrAddr   <= a;
    sfrWdata  <= d;
    sfrBitIdx <= d[2:0];
    sfrBitVal <= d[3];
    @(posedge clk);
    sfrWr    <= 0;
    sfrBitWr <= 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_fetch;
    go(1, 0, 0, 16'h0fff, 0);
    chk("romLat", n, 2);
    chk("romByte", fetchData, 8'h3c);
    chk("romStrobe", nF, 0);
    go(1, 0, 0, 16'h1000, 0);
    chk("extLat", n, LAT);
    chk("extByte", fetchData, memf(16'h1000));
    chk("fetchLen", nF, STB);
    chk("fetchOther", nR + nS, 0);
    $display("fetch test over");
  endtask
  task automatic t_data;
    go(0, 0, 1, 16'h2345, 0);
    chk("rdByte", dataRdata, memf(16'h2345));
    chk("rdLen", nR, STB);
    chk("rdOther", nF + nS, 0);
    chk("rdLat", n, LAT);
    go(0, 1, 1, 16'h3456, 8'ha5);
    chk("wrData", wrData, 8'ha5);
    chk("wrAddr", wrAddr, 16'h3456);
    chk("wrLen", nS, STB);
    chk("wrOther", nF + nR, 0);
    sfr(0, 8'ha0, 8'h12);
    go(0, 0, 0, 16'h0077, 0);
    chk("pageByte", dataRdata, memf(16'h1277));
    chk("pageHigh", hiE, 8'hed);
    sfr(0, 8'ha0, 8'hff);
    $display("data test over");
  endtask
  task automatic t_port;
    sfr(0, 8'h90, 8'h3c);
    sfr(0, 8'he0, 8'h00);
    sfr(1, 8'h90, 8'h08);
    chk("latch", portLatch, 32'hffff3dff);
    chk("gpOe", gpE, 8'hc2);
    repeat (3) @(negedge clk);
    chk("gpPins", portPins[15:8], 8'h3d);
    $display("port test over");
  endtask
  task automatic t_alt;
    int nI;
    nI = 0;
    @(posedge clk);
    irqEdgeMode <= 2'b01;
    altExt      <= 8'he2;
    repeat (8) begin
      @(negedge clk);
      nI += irqReq[0];
    end
    chk("edgeIrq", nI, 1);
    chk("levelIrq", irqReq[1], 1);
    chk("count", countIn, 2'b10);
    chk("rxd", serRxd, 0);
    @(posedge clk);
    altExt    <= 8'hff;
    serTxd    <= 0;
    serDataOe <= 1;
    repeat (3) @(negedge clk);
    chk("txLow", alE[1], 1);
    @(posedge clk);
    serShiftMode <= 1;
    serTxd       <= 1;
    serShiftClk  <= 0;
    serDataOut   <= 0;
    repeat (3) @(negedge clk);
    chk("shiftClk", alE[1], 1);
    chk("shiftData", alE[0], 1);
    sfr(0, 8'hb0, 8'hdf);
    chk("altIo", alE[5], 1);
    chk("altIdle", alE[7:6], 2'b00);
    $display("alternate test over");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(negedge clk);
    chk("rstLatch", portLatch, 32'hffffffff);
    t_fetch();
    t_data();
    t_port();
    t_alt();
    stop_test();
  end
endmodule
`default_nettype wire
